// ===== verilog/cmb_pkg.sv
/*
  Shared constants and types for the controller mode command builder.
  Assumes the host writes a send block of 16-bit words, offset +0 first,
  and that controller-side transport sits beyond the command port.
*/
package cmb_pkg;

  // ----------------------------------------------------------------
  // Send block geometry
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 16;
  localparam int          ADDR_W     = 7;
  localparam int          BLK_DEPTH  = 66;          // Words +0 to +65
  localparam logic [6:0]  OFF_COUNT  = 7'h00;       // Send word count
  localparam logic [6:0]  OFF_UNITS  = 7'h01;       // Unit count
  localparam logic [6:0]  OFF_FIRST  = 7'h02;       // First unit record
  localparam logic [6:0]  HEAD_WORDS = 7'h02;

  // ----------------------------------------------------------------
  // Field limits, binary after BCD decode
  // ----------------------------------------------------------------
  localparam logic [13:0] UNITS_MIN   = 14'h0001;
  localparam logic [13:0] UNITS_MAX   = 14'h0020;   // 32 units
  localparam logic [6:0]  UNIT_NO_MAX = 7'h1f;      // Unit 31
  localparam logic [13:0] PATTERN_MAX = 14'h003f;   // Pattern/bank 63
  localparam logic [13:0] PID_SET_MAX = 14'h0008;   // PID set 8

  // ----------------------------------------------------------------
  // Sequence numbers, three BCD digits
  // ----------------------------------------------------------------
  localparam logic [11:0] SEQ_EXT_SET   = 12'h270;
  localparam logic [11:0] SEQ_RUN       = 12'h271;
  localparam logic [11:0] SEQ_STOP      = 12'h272;
  localparam logic [11:0] SEQ_AUTO      = 12'h273;
  localparam logic [11:0] SEQ_MANUAL    = 12'h274;
  localparam logic [11:0] SEQ_AT_START  = 12'h275;
  localparam logic [11:0] SEQ_AT_CANCEL = 12'h276;

  // ----------------------------------------------------------------
  // Setting mode status codes, two BCD digits
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_LOCAL    = 8'h00;
  localparam logic [7:0]  MODE_REMOTE   = 8'h01;
  localparam logic [7:0]  MODE_EXTERNAL = 8'h02;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RECV_WORDS_NONE = 16'h0000;
  localparam logic [7:0]  MODE_RESET      = 8'h00;

  // Commands presented to the controller side
  typedef enum logic [2:0] {
    CMD_EXT_SET,
    CMD_RUN,
    CMD_STOP,
    CMD_AUTO,
    CMD_MANUAL,
    CMD_AT_START,
    CMD_AT_CANCEL
  } cmb_cmd_type;

endpackage

// ===== verilog/cmb_block_ram.sv
/*
  Send block store: one write port for the host, one read port for the
  interpreter. Read data come out of a register one cycle after rd_en.
  Assumes a single clock and no simultaneous need for read-during-write.
*/
`timescale 1ns/10ps
module cmb_block_ram
(
  // Clock
  input  logic                          clock,
  // Host write side
  input  logic                          wr_en,
  input  logic [cmb_pkg::ADDR_W-1:0]    wr_addr,
  input  logic [cmb_pkg::WORD_W-1:0]    wr_data,
  // Interpreter read side
  input  logic                          rd_en,
  input  logic [cmb_pkg::ADDR_W-1:0]    rd_addr,
  output logic [cmb_pkg::WORD_W-1:0]    rd_data
);

  logic [cmb_pkg::WORD_W-1:0] mem [cmb_pkg::BLK_DEPTH];

  // ----------------------------------------------------------------
  // Storage; no reset, content is defined by the host before a call
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (wr_en && (wr_addr < 7'(cmb_pkg::BLK_DEPTH)))
      mem[wr_addr] <= wr_data;
    if (rd_en)
      rd_data <= (rd_addr < 7'(cmb_pkg::BLK_DEPTH)) ? mem[rd_addr] : '0;
  end

endmodule

// ===== verilog/cmb_command_builder.sv
/*
  Controller mode command builder: checks a send block for one of the
  mode and control sequences and issues one command per listed unit.
  Assumes the host fills the block before pulsing call_start and leaves
  it untouched while call_busy is high; the controller side takes a
  command when cmd_valid and cmd_ready are both high.
*/
// Overview of operation
// RULE1: Sequence 270 sends an external-setting-mode command to each listed unit.
// RULE2: Word +0 holds total send words in BCD; unit count plus two.
// RULE3: Word +1 holds unit count in BCD, 0001 to 0032.
// RULE4: Single-word layout: unit numbers 00 to 31 from +2, last at +33.
// RULE5: Sequence 271 runs units; unit plus pattern/bank 0000-0063, twice plus two.
// RULE6: Sequence 272 stops control on each listed unit, one word per unit.
// RULE7: Sequence 273 switches each listed unit to automatic control.
// RULE8: Sequence 274 switches each listed unit to manual control.
// RULE9: Sequence 275 starts tuning; unit plus PID set 0000-0008 per unit.
// RULE10: Sequence 276 cancels tuning on each listed unit, one word per unit.
// RULE11: These sequences return no data words to the host.
// RULE12: Setting mode status codes: 00 local, 01 remote, 02 external.
// RULE13: Blocks with bad count, non-BCD digits or out-of-range values issue nothing.
// RULE14: Commands go out one at a time in send block order.
`timescale 1ns/10ps
module cmb_command_builder
(
  // Clock and reset
  input  logic                          clock,
  input  logic                          rst_n,
  // Host send block write port
  input  logic                          blk_wr_en,
  input  logic [cmb_pkg::ADDR_W-1:0]    blk_wr_addr,
  input  logic [cmb_pkg::WORD_W-1:0]    blk_wr_data,
  // Sequence call
  input  logic                          call_start,
  input  logic [11:0]                   call_seq,
  // Call status
  output logic                          call_busy,
  output logic                          call_done,
  output logic                          call_error,
  output logic [15:0]                   recv_word_count,
  output logic [7:0]                    setting_mode_status,
  // Controller command port
  output logic                          cmd_valid,
  output cmb_pkg::cmb_cmd_type          cmd_code,
  output logic [4:0]                    cmd_unit,
  output logic [6:0]                    cmd_arg,
  input  logic                          cmd_ready
);

  typedef enum {S_IDLE, S_RD_REQ, S_RD_USE, S_CHECK, S_ISSUE} cmb_state_type;

  cmb_state_type              state, next_state;
  logic [6:0]                 ptr, next_ptr;
  logic [6:0]                 last_ptr, next_last_ptr;
  logic [13:0]                count, next_count;
  logic                       pair, next_pair;        // Two words per unit
  logic                       issuing, next_issuing;
  logic                       bad, next_bad;
  logic [11:0]                seq, next_seq;
  logic                       rd_en;
  logic [15:0]                rd_data;
  logic                       next_busy, next_done, next_error, next_cmd_valid;
  cmb_pkg::cmb_cmd_type       next_cmd_code;
  logic [4:0]                 next_cmd_unit;
  logic [6:0]                 next_cmd_arg;
  logic [7:0]                 next_mode;
  logic [13:0]                units_bin;
  logic [6:0]                 total;
  logic [13:0]                word_val;               // Whole word as binary
  logic [13:0]                unit_val;               // Low byte only, as binary

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  function automatic logic bcd_ok(input logic [15:0] w);
    bcd_ok = (w[3:0] < 4'ha) && (w[7:4] < 4'ha) && (w[11:8] < 4'ha) && (w[15:12] < 4'ha);
  endfunction

  function automatic logic [13:0] bcd_val(input logic [15:0] w);
    // Widen each digit first so no partial product wraps
    bcd_val = 14'(w[15:12]) * 14'h3e8 + 14'(w[11:8]) * 14'h064
            + 14'(w[7:4]) * 14'h00a + 14'(w[3:0]);
  endfunction

  cmb_block_ram u_ram
  (
    .clock   (clock),
    .wr_en   (blk_wr_en),
    .wr_addr (blk_wr_addr),
    .wr_data (blk_wr_data),
    .rd_en   (rd_en),
    .rd_addr (ptr),
    .rd_data (rd_data)
  );

  // Expected block length from the unit count just read
  assign units_bin = bcd_val(rd_data);
  assign word_val  = bcd_val(rd_data);
  assign unit_val  = bcd_val({8'h00, rd_data[7:0]});
  assign total     = pair ? 7'((units_bin[5:0] << 1) + cmb_pkg::HEAD_WORDS)
                          : 7'(units_bin[5:0] + cmb_pkg::HEAD_WORDS);

  // ----------------------------------------------------------------
  // Sequencer: validate pass, then issue pass over the same block
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_ptr       = ptr;
    next_last_ptr  = last_ptr;
    next_count     = count;
    next_pair      = pair;
    next_issuing   = issuing;
    next_bad       = bad;
    next_seq       = seq;
    next_done      = 1'b0;
    next_error     = 1'b0;
    next_cmd_valid = cmd_valid;
    next_cmd_code  = cmd_code;
    next_cmd_unit  = cmd_unit;
    next_cmd_arg   = cmd_arg;
    next_mode      = setting_mode_status;
    rd_en          = 1'b0;
    unique case (state)
      S_IDLE:
      begin
        if (call_start)
        begin
          next_seq     = call_seq;
          next_ptr     = cmb_pkg::OFF_COUNT;
          next_issuing = 1'b0;
          next_bad     = 1'b0;
          next_pair    = (call_seq == cmb_pkg::SEQ_RUN) || (call_seq == cmb_pkg::SEQ_AT_START);
          next_state   = S_RD_REQ;
          // Sequence to command mapping
          unique case (call_seq)
            cmb_pkg::SEQ_EXT_SET:   next_cmd_code = cmb_pkg::CMD_EXT_SET;   // RULE1
            cmb_pkg::SEQ_RUN:       next_cmd_code = cmb_pkg::CMD_RUN;       // RULE5
            cmb_pkg::SEQ_STOP:      next_cmd_code = cmb_pkg::CMD_STOP;      // RULE6
            cmb_pkg::SEQ_AUTO:      next_cmd_code = cmb_pkg::CMD_AUTO;      // RULE7
            cmb_pkg::SEQ_MANUAL:    next_cmd_code = cmb_pkg::CMD_MANUAL;    // RULE8
            cmb_pkg::SEQ_AT_START:  next_cmd_code = cmb_pkg::CMD_AT_START;  // RULE9
            cmb_pkg::SEQ_AT_CANCEL: next_cmd_code = cmb_pkg::CMD_AT_CANCEL; // RULE10
            default:
            begin
              // Unknown sequence: refuse at once, nothing issued
              next_state = S_IDLE;
              next_done  = 1'b1;
              next_error = 1'b1;
            end
          endcase
        end
      end
      S_RD_REQ:
      begin
        rd_en      = 1'b1;
        next_state = S_RD_USE;
      end
      S_RD_USE:
      begin
        if (!issuing)
        begin
          next_ptr   = 7'(ptr + 7'h01);
          next_state = S_RD_REQ;
          if (ptr == cmb_pkg::OFF_COUNT)
          begin
            next_count = bcd_val(rd_data);
            next_bad   = !bcd_ok(rd_data);
          end
          else if (ptr == cmb_pkg::OFF_UNITS)
          begin
            // Count must match the layout of this sequence
            next_last_ptr = 7'(total - 7'h01);
            if (!bcd_ok(rd_data) || (units_bin < cmb_pkg::UNITS_MIN)
                || (units_bin > cmb_pkg::UNITS_MAX) || (count != {7'h00, total}))
            begin
              next_bad   = 1'b1;                          // RULE13
              next_state = S_CHECK;
            end
          end
          else
          begin
            if (pair && ptr[0])
            begin
              // Pattern/bank or PID set word
              if (!bcd_ok(rd_data) || (bcd_val(rd_data) > ((seq == cmb_pkg::SEQ_RUN)
                  ? cmb_pkg::PATTERN_MAX : cmb_pkg::PID_SET_MAX)))
                next_bad = 1'b1;                          // RULE13
            end
            else if (!bcd_ok({8'h00, rd_data[7:0]})
                     || (bcd_val({8'h00, rd_data[7:0]}) > {7'h00, cmb_pkg::UNIT_NO_MAX}))
              next_bad = 1'b1;                            // RULE13
            if (ptr == last_ptr)
              next_state = S_CHECK;
          end
        end
        else if (pair && ptr[0])
        begin
          next_cmd_arg   = word_val[6:0];                 // RULE5 RULE9
          next_cmd_valid = 1'b1;
          next_state     = S_ISSUE;
        end
        else
        begin
          // Upper byte of a unit word is undefined and ignored
          next_cmd_unit = unit_val[4:0];
          next_cmd_arg  = 7'h00;
          if (pair)
          begin
            next_ptr   = 7'(ptr + 7'h01);
            next_state = S_RD_REQ;
          end
          else
          begin
            next_cmd_valid = 1'b1;
            next_state     = S_ISSUE;
          end
        end
      end
      S_CHECK:
      begin
        if (bad)
        begin
          next_state = S_IDLE;                            // RULE13
          next_done  = 1'b1;
          next_error = 1'b1;
        end
        else
        begin
          next_issuing = 1'b1;
          next_ptr     = cmb_pkg::OFF_FIRST;
          next_state   = S_RD_REQ;
        end
      end
      S_ISSUE:
      begin
        // One command in flight; the next unit waits for acceptance
        if (cmd_ready)
        begin
          next_cmd_valid = 1'b0;                          // RULE14
          if (ptr == last_ptr)
          begin
            next_state = S_IDLE;
            next_done  = 1'b1;
            if (seq == cmb_pkg::SEQ_EXT_SET)
              next_mode = cmb_pkg::MODE_EXTERNAL;         // RULE12
          end
          else
          begin
            next_ptr   = 7'(ptr + 7'h01);
            next_state = S_RD_REQ;
          end
        end
      end
    endcase
    next_busy = (next_state != S_IDLE);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state               <= S_IDLE;
      ptr                 <= 7'h00;
      last_ptr            <= 7'h00;
      count               <= 14'h0000;
      pair                <= 1'b0;
      issuing             <= 1'b0;
      bad                 <= 1'b0;
      seq                 <= 12'h000;
      call_busy           <= 1'b0;
      call_done           <= 1'b0;
      call_error          <= 1'b0;
      recv_word_count     <= cmb_pkg::RECV_WORDS_NONE;
      setting_mode_status <= cmb_pkg::MODE_RESET;
      cmd_valid           <= 1'b0;
      cmd_code            <= cmb_pkg::CMD_EXT_SET;
      cmd_unit            <= 5'h00;
      cmd_arg             <= 7'h00;
    end
    else
    begin
      state               <= next_state;
      ptr                 <= next_ptr;
      last_ptr            <= next_last_ptr;
      count               <= next_count;
      pair                <= next_pair;
      issuing             <= next_issuing;
      bad                 <= next_bad;
      seq                 <= next_seq;
      call_busy           <= next_busy;
      call_done           <= next_done;
      call_error          <= next_error;
      recv_word_count     <= cmb_pkg::RECV_WORDS_NONE; // RULE11
      setting_mode_status <= next_mode;
      cmd_valid           <= next_cmd_valid;
      cmd_code            <= next_cmd_code;
      cmd_unit            <= next_cmd_unit;
      cmd_arg             <= next_cmd_arg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Helper: any command shown during the current call
  logic issued;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      issued <= 1'b0;
    else if (call_start && !call_busy)
      issued <= 1'b0;
    else if (cmd_valid)
      issued <= 1'b1;
  end

  a_ext_code: assert property (cmd_valid && seq == cmb_pkg::SEQ_EXT_SET // RULE1
    |-> cmd_code == cmb_pkg::CMD_EXT_SET) else $error("wrong code for 270");
  a_run_arg: assert property (cmd_valid && seq == cmb_pkg::SEQ_RUN // RULE5
    |-> cmd_code == cmb_pkg::CMD_RUN && {7'h00, cmd_arg} <= cmb_pkg::PATTERN_MAX)
    else $error("bad run command");
  a_stop_code: assert property (cmd_valid && seq == cmb_pkg::SEQ_STOP // RULE6
    |-> cmd_code == cmb_pkg::CMD_STOP) else $error("wrong code for 272");
  a_auto_code: assert property (cmd_valid && seq == cmb_pkg::SEQ_AUTO // RULE7
    |-> cmd_code == cmb_pkg::CMD_AUTO) else $error("wrong code for 273");
  a_manual_code: assert property (cmd_valid && seq == cmb_pkg::SEQ_MANUAL // RULE8
    |-> cmd_code == cmb_pkg::CMD_MANUAL) else $error("wrong code for 274");
  a_tune_arg: assert property (cmd_valid && seq == cmb_pkg::SEQ_AT_START // RULE9
    |-> cmd_code == cmb_pkg::CMD_AT_START && {7'h00, cmd_arg} <= cmb_pkg::PID_SET_MAX)
    else $error("bad tune command");
  a_cancel_code: assert property (cmd_valid && seq == cmb_pkg::SEQ_AT_CANCEL // RULE10
    |-> cmd_code == cmb_pkg::CMD_AT_CANCEL) else $error("wrong code for 276");
  a_no_receive: assert property (call_done |-> recv_word_count == 16'h0000) // RULE11
    else $error("receive words reported");
  a_ext_status: assert property (call_done && !call_error && seq == cmb_pkg::SEQ_EXT_SET // RULE12
    |-> setting_mode_status == cmb_pkg::MODE_EXTERNAL) else $error("external mode not reported");
  a_reject_silent: assert property (call_done && call_error |-> !issued) // RULE13
    else $error("command issued for rejected block");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready // RULE14
    |=> cmd_valid && $stable(cmd_unit) && $stable(cmd_arg)) else $error("command dropped");
  a_one_gap: assert property (cmd_valid && cmd_ready |=> !cmd_valid) // RULE14
    else $error("commands back to back");

  c_run_ok: cover property (call_done && !call_error && seq == cmb_pkg::SEQ_RUN);
  c_ext_ok: cover property (call_done && !call_error && seq == cmb_pkg::SEQ_EXT_SET);
  c_reject: cover property (call_done && call_error);
  c_stall:  cover property (cmd_valid && !cmd_ready ##1 cmd_valid && cmd_ready);

endmodule

// ===== test/cmb_controller_model.sv
/*
  Controller-side model of the command port: takes commands after a
  settable stall and logs every accepted command in arrival order.
  Assumes one clock, ready/valid sampled on the rising edge.
*/
`timescale 1ns/10ps
module cmb_controller_model
(
  // Clock and reset
  input  logic                 clock,
  input  logic                 rst_n,
  // Command port from the builder
  input  logic                 cmd_valid,
  input  cmb_pkg::cmb_cmd_type cmd_code,
  input  logic [4:0]           cmd_unit,
  input  logic [6:0]           cmd_arg,
  output logic                 cmd_ready,
  // Bench control
  input  logic [3:0]           stall_cycles
);
  // ----------------------------------------------------------------
  // Accepted command log
  // ----------------------------------------------------------------
  cmb_pkg::cmb_cmd_type log_code [0:63];
  logic [4:0]           log_unit [0:63];
  logic [6:0]           log_arg  [0:63];
  int                   n_log;
  logic [3:0]           wait_cnt;

  // Ready only after the stall count, so slow lines are exercised too
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_ready <= 1'b0;
      wait_cnt  <= 4'h0;
      n_log     <= 0;
    end
    else if (cmd_valid && cmd_ready)
    begin
      log_code[n_log % 64] <= cmd_code;
      log_unit[n_log % 64] <= cmd_unit;
      log_arg[n_log % 64]  <= cmd_arg;
      n_log                <= n_log + 1;
      cmd_ready            <= 1'b0;
      wait_cnt             <= 4'h0;
    end
    else if (cmd_valid)
    begin
      if (wait_cnt >= stall_cycles)
        cmd_ready <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ===== test/controller_mode_command_builder_test.sv
/*
  Self-checking bench for the command builder: fills send blocks, calls
  each sequence, and compares the issued commands against the block.
  Assumes the controller model in its own file; one 100 MHz clock.
*/
`timescale 1ns/10ps
module controller_mode_command_builder_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 clock;
  logic                 rst_n;
  logic                 blk_wr_en;
  logic [6:0]           blk_wr_addr;
  logic [15:0]          blk_wr_data;
  logic                 call_start;
  logic [11:0]          call_seq;
  logic                 call_busy;
  logic                 call_done;
  logic                 call_error;
  logic [15:0]          recv_word_count;
  logic [7:0]           setting_mode_status;
  logic                 cmd_valid;
  cmb_pkg::cmb_cmd_type cmd_code;
  logic [4:0]           cmd_unit;
  logic [6:0]           cmd_arg;
  logic                 cmd_ready;
  logic [3:0]           stall_cycles;
  int                   miscompares;
  int                   cmp_count;
  int                   base;

  cmb_command_builder i_dut (.clock(clock), .rst_n(rst_n), .blk_wr_en(blk_wr_en),
    .blk_wr_addr(blk_wr_addr), .blk_wr_data(blk_wr_data), .call_start(call_start),
    .call_seq(call_seq), .call_busy(call_busy), .call_done(call_done),
    .call_error(call_error), .recv_word_count(recv_word_count),
    .setting_mode_status(setting_mode_status), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_unit(cmd_unit), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready));

  cmb_controller_model i_ctl (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_unit(cmd_unit), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .stall_cycles(stall_cycles));

  // Free-running clock, 10 ns period
  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Plain decimal to BCD digits, bench side only
  function automatic logic [15:0] bcd(input int v);
    return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
  endfunction

  task automatic put(input int addr, input logic [15:0] data);
    @(negedge clock);
    blk_wr_en   = 1'b1;
    blk_wr_addr = 7'(addr);
    blk_wr_data = data;
    @(negedge clock);
    blk_wr_en   = 1'b0;
  endtask

  // Starts a call, waits for done, checks error flag and command count
  task automatic do_call(input logic [11:0] seq, input int n, input logic exp_err);
    int t;
    base = i_ctl.n_log;
    @(negedge clock);
    call_start = 1'b1;
    call_seq   = seq;
    @(negedge clock);
    call_start = 1'b0;
    chk(call_busy, (seq >= 12'h270) && (seq <= 12'h276), "busy after start");
    t = 0;
    while (call_done !== 1'b1)
    begin
      @(negedge clock);
      t++;
      if (t > 3000)
      begin
        miscompares++;
        $display("[FAIL] %0t call never completed", $time);
        tally_and_finish();
      end
    end
    chk(call_error, exp_err, "error flag");
    chk(call_busy, 1'b0, "busy at done");
    chk(recv_word_count, 0, "receive words");
    chk(i_ctl.n_log - base, n, "command count");
  endtask

  task automatic chk_cmd(input int k, input cmb_pkg::cmb_cmd_type c, input int u, input int a);
    chk(i_ctl.log_code[(base + k) % 64], c, "command code");
    chk(i_ctl.log_unit[(base + k) % 64], u, "unit number");
    chk(i_ctl.log_arg[(base + k) % 64], a, "argument");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every one-word sequence, three units with edge unit numbers
  task automatic one_word_sequences();
    logic [11:0]          seqs [5] = '{12'h270, 12'h272, 12'h273, 12'h274, 12'h276};
    cmb_pkg::cmb_cmd_type codes [5] = '{cmb_pkg::CMD_EXT_SET, cmb_pkg::CMD_STOP,
      cmb_pkg::CMD_AUTO, cmb_pkg::CMD_MANUAL, cmb_pkg::CMD_AT_CANCEL};
    int                   ul [3] = '{31, 0, 5};
    stall_cycles = 4'h0;
    chk(setting_mode_status, 8'h00, "local after reset");
    put(0, bcd(5));
    put(1, bcd(3));
    for (int i = 0; i < 3; i++)
      put(2 + i, 16'hff00 | bcd(ul[i]));
    for (int s = 0; s < 5; s++)
    begin
      do_call(seqs[s], 3, 1'b0);
      for (int i = 0; i < 3; i++)
        chk_cmd(i, codes[s], ul[i], 0);
      if (s == 0)
        chk(setting_mode_status, 8'h02, "external mode");
    end
  endtask

  // Full block of 32 units, last unit word at +33
  task automatic full_block();
    stall_cycles = 4'h1;
    put(0, bcd(34));
    put(1, bcd(32));
    for (int i = 0; i < 32; i++)
      put(2 + i, bcd(31 - i));
    do_call(12'h272, 32, 1'b0);
    for (int i = 0; i < 32; i++)
      chk_cmd(i, cmb_pkg::CMD_STOP, 31 - i, 0);
  endtask

  // Paired layouts at their argument limits, slow controller
  task automatic paired_sequences();
    stall_cycles = 4'h3;
    put(0, bcd(6));
    put(1, bcd(2));
    put(2, bcd(7));
    put(3, bcd(63));
    put(4, bcd(31));
    put(5, bcd(0));
    do_call(12'h271, 2, 1'b0);
    chk_cmd(0, cmb_pkg::CMD_RUN, 7, 63);
    chk_cmd(1, cmb_pkg::CMD_RUN, 31, 0);
    put(3, bcd(8));
    put(5, bcd(1));
    do_call(12'h275, 2, 1'b0);
    chk_cmd(0, cmb_pkg::CMD_AT_START, 7, 8);
    chk_cmd(1, cmb_pkg::CMD_AT_START, 31, 1);
  endtask

  // Bad blocks issue nothing and flag an error
  task automatic bad(input logic [11:0] seq, input logic [15:0] w0, input logic [15:0] w1,
                     input logic [15:0] w2, input logic [15:0] w3);
    put(0, w0);
    put(1, w1);
    put(2, w2);
    put(3, w3);
    do_call(seq, 0, 1'b1);
  endtask

  task automatic rejects();
    stall_cycles = 4'h0;
    bad(12'h272, 16'h0004, 16'h0001, 16'h0005, 16'h0000);
    bad(12'h272, 16'h0002, 16'h0000, 16'h0005, 16'h0000);
    bad(12'h272, 16'h000a, 16'h0001, 16'h0005, 16'h0000);
    bad(12'h273, 16'h0003, 16'h0001, 16'h0032, 16'h0000);
    bad(12'h276, 16'h0003, 16'h0001, 16'h001a, 16'h0000);
    bad(12'h271, 16'h0004, 16'h0001, 16'h0005, 16'h0064);
    bad(12'h275, 16'h0004, 16'h0001, 16'h0005, 16'h0009);
    bad(12'h271, 16'h0003, 16'h0001, 16'h0005, 16'h0001);
    bad(12'h277, 16'h0003, 16'h0001, 16'h0005, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock        = 1'b0;
    rst_n        = 1'b0;
    blk_wr_en    = 1'b0;
    blk_wr_addr  = 7'h00;
    blk_wr_data  = 16'h0000;
    call_start   = 1'b0;
    call_seq     = 12'h000;
    stall_cycles = 4'h0;
    miscompares  = 0;
    cmp_count    = 0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    one_word_sequences();
    full_block();
    paired_sequences();
    rejects();
    tally_and_finish();
  end
endmodule
